// [hdl/hpc_cfg_regs.sv]
// Hub power and string configuration registers with descriptor reads.
// Assumes a byte configuration port and a descriptor engine on CLK.
`timescale 1ns/1ns
module hpc_cfg_regs #(
  parameter logic [7:0]  NUM_PORTS = 8'h03,
  parameter logic [15:0] HUB_CHAR  = 16'h0000
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic        CFG_WR,
  input  wire logic        CFG_RD,
  input  wire logic [7:0]  CFG_WDATA,
  output logic      [7:0]  CFG_RDATA,
  output logic             CFG_RVALID,
  input  wire logic        SELF_PWR_PIN,
  input  wire logic        DESC_REQ,
  input  wire logic [1:0]  DESC_KIND,
  input  wire logic [7:0]  DESC_IDX,
  output logic      [7:0]  DESC_BYTE,
  output logic             DESC_VALID,
  output logic      [15:0] LANG_ID
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] bus_pwr_r;
  logic [7:0] self_cur_r;
  logic [7:0] bus_cur_r;
  logic [7:0] pwr_on_r;
  logic [7:0] lang_up_r;
  logic [7:0] lang_lo_r;
  logic [7:0] maker_len_r;
  logic [7:0] prod_len_r;
  logic [7:0] ser_len_r;
  logic [2:0] sp_sync_r;
  logic       self_pwr_r;
  logic       str_wr;
  logic [5:0] str_wr_addr;
  logic [7:0] str_cfg_byte;
  logic [5:0] str_desc_addr;
  logic [7:0] str_desc_byte;
  logic [7:0] desc_nxt;
  logic [7:0] rdata_nxt;

  // ****************************************************************
  // Configuration writes
  // ****************************************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bus_pwr_r   <= hpc_pkg::RST_BUS_PWR;
      self_cur_r  <= hpc_pkg::RST_SELF_CUR;
      bus_cur_r   <= hpc_pkg::RST_BUS_CUR;
      pwr_on_r    <= hpc_pkg::RST_PWR_ON;
      lang_up_r   <= hpc_pkg::RST_LANG_UP;
      lang_lo_r   <= hpc_pkg::RST_LANG_LO;
      maker_len_r <= hpc_pkg::RST_MAKER_LEN;
      prod_len_r  <= hpc_pkg::RST_PROD_LEN;
      ser_len_r   <= hpc_pkg::RST_SER_LEN;
    end else if (CFG_WR) begin
      // Values stored as written; range limits are software's duty
      unique case (CFG_ADDR)
        hpc_pkg::OFF_BUS_PWR:   bus_pwr_r   <= CFG_WDATA;
        hpc_pkg::OFF_SELF_CUR:  self_cur_r  <= CFG_WDATA;
        hpc_pkg::OFF_BUS_CUR:   bus_cur_r   <= CFG_WDATA;
        hpc_pkg::OFF_PWR_ON:    pwr_on_r    <= CFG_WDATA;
        hpc_pkg::OFF_LANG_UP:   lang_up_r   <= CFG_WDATA;
        hpc_pkg::OFF_LANG_LO:   lang_lo_r   <= CFG_WDATA;
        hpc_pkg::OFF_MAKER_LEN: maker_len_r <= CFG_WDATA;
        hpc_pkg::OFF_PROD_LEN:  prod_len_r  <= CFG_WDATA;
        hpc_pkg::OFF_SER_LEN:   ser_len_r   <= CFG_WDATA;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Maker string storage
  // ****************************************************************
  assign str_wr      = CFG_WR && hpc_pkg::in_maker_str(CFG_ADDR);
  assign str_wr_addr = 6'(CFG_ADDR - hpc_pkg::OFF_STR_FIRST);

  hpc_str_mem #(
    .DEPTH (hpc_pkg::STR_DEPTH),
    .AW    (hpc_pkg::STR_AW)
  ) u_str (
    .clk       (CLK),
    .rst_n     (RST_N),
    .wr_en     (str_wr),
    .wr_addr   (str_wr_addr),
    .wr_data   (CFG_WDATA),
    .rd_a_addr (str_wr_addr),
    .rd_a_data (str_cfg_byte),
    .rd_b_addr (str_desc_addr),
    .rd_b_data (str_desc_byte)
  );

  // ****************************************************************
  // Configuration reads
  // ****************************************************************
  // A read in the same cycle as a write returns the old value
  always_comb begin
    rdata_nxt = 8'h00;
    if (hpc_pkg::in_maker_str(CFG_ADDR)) begin
      rdata_nxt = str_cfg_byte;
    end else begin
      unique case (CFG_ADDR)
        hpc_pkg::OFF_BUS_PWR:   rdata_nxt = bus_pwr_r;
        hpc_pkg::OFF_SELF_CUR:  rdata_nxt = self_cur_r;
        hpc_pkg::OFF_BUS_CUR:   rdata_nxt = bus_cur_r;
        hpc_pkg::OFF_PWR_ON:    rdata_nxt = pwr_on_r;
        hpc_pkg::OFF_LANG_UP:   rdata_nxt = lang_up_r;
        hpc_pkg::OFF_LANG_LO:   rdata_nxt = lang_lo_r;
        hpc_pkg::OFF_MAKER_LEN: rdata_nxt = maker_len_r;
        hpc_pkg::OFF_PROD_LEN:  rdata_nxt = prod_len_r;
        hpc_pkg::OFF_SER_LEN:   rdata_nxt = ser_len_r;
        default:                rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CFG_RDATA  <= 8'h00;
      CFG_RVALID <= 1'b0;
    end else begin
      CFG_RVALID <= CFG_RD;
      if (CFG_RD) begin
        CFG_RDATA <= rdata_nxt;
      end
    end
  end

  // ****************************************************************
  // Power mode pin
  // ****************************************************************
  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sp_sync_r  <= 3'h0;
      self_pwr_r <= 1'b0;
    end else begin
      sp_sync_r <= {sp_sync_r[1:0], SELF_PWR_PIN};
      if (sp_sync_r[1] == sp_sync_r[2]) begin
        self_pwr_r <= sp_sync_r[2];
      end
    end
  end

  // ****************************************************************
  // Descriptor bytes
  // ****************************************************************
  hpc_desc_gen #(
    .NUM_PORTS (NUM_PORTS),
    .HUB_CHAR  (HUB_CHAR)
  ) u_gen (
    .kind      (DESC_KIND),
    .idx       (DESC_IDX),
    .self_pwr  (self_pwr_r),
    .bus_pwr   (bus_pwr_r),
    .self_cur  (self_cur_r),
    .bus_cur   (bus_cur_r),
    .pwr_on    (pwr_on_r),
    .lang_up   (lang_up_r),
    .lang_lo   (lang_lo_r),
    .maker_len (maker_len_r),
    .str_byte  (str_desc_byte),
    .str_addr  (str_desc_addr),
    .byte_o    (desc_nxt)
  );

  // Live registers feed each request, no snapshot is kept
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DESC_BYTE  <= 8'h00;
      DESC_VALID <= 1'b0;
    end else begin
      DESC_VALID <= DESC_REQ;
      if (DESC_REQ) begin
        DESC_BYTE <= desc_nxt;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      LANG_ID <= {hpc_pkg::RST_LANG_UP, hpc_pkg::RST_LANG_LO};
    end else begin
      LANG_ID <= {lang_up_r, lang_lo_r};
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic first_r;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) first_r <= 1'b0;
    else        first_r <= 1'b1;
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_wr(logic [7:0] a);
    CFG_WR && CFG_ADDR == a;
  endsequence

  sequence s_rd(logic [7:0] a);
    CFG_RD && !CFG_WR && CFG_ADDR == a;
  endsequence

  sequence s_req(hpc_pkg::hpc_kind_e k, logic [7:0] i);
    DESC_REQ && DESC_KIND == k && DESC_IDX == i && !CFG_WR;
  endsequence

  a_power_reset: assert property (!first_r |->
      bus_pwr_r == 8'hFA && bus_cur_r == 8'h64 && self_cur_r == 8'h02)
    else $error("power bytes wrong after reset");

  a_lang_reset: assert property (!first_r |=> LANG_ID == 16'h0409
      || $past(CFG_WR))
    else $error("language id wrong after reset");

  a_lens_reset: assert property (!first_r |->
      prod_len_r == 8'h00 && ser_len_r == 8'h00 && pwr_on_r == 8'h00)
    else $error("length or time byte not zero after reset");

  a_bus_pwr_rdbk: assert property (s_wr(8'h0D) ##1 s_rd(8'h0D)
      |=> CFG_RVALID && CFG_RDATA == $past(CFG_WDATA, 2))
    else $error("bus power readback mismatch");

  a_unmapped_rd: assert property (s_rd(8'h00) |=>
      CFG_RVALID && CFG_RDATA == 8'h00)
    else $error("unmapped read not zero");

  a_lang_desc: assert property (s_req(hpc_pkg::KIND_LANG, 8'h02)
      |=> DESC_VALID && DESC_BYTE == $past(lang_lo_r))
    else $error("language low byte not sent");

  a_pwron_desc: assert property (s_wr(8'h10) ##1
      s_req(hpc_pkg::KIND_HUB, 8'h05)
      |=> DESC_BYTE == $past(CFG_WDATA, 2))
    else $error("power-on time not in hub descriptor");

  a_maker_len: assert property (s_req(hpc_pkg::KIND_MAKER, 8'h00)
      |=> DESC_BYTE == 8'($past(maker_len_r) + 8'h02))
    else $error("maker descriptor length wrong");

  a_char_low: assert property (s_wr(8'h16) ##1 s_wr(8'h13)
      ##1 s_req(hpc_pkg::KIND_MAKER, 8'h02)
      |=> $past(CFG_WDATA, 2) < 8'h01 || DESC_BYTE == $past(CFG_WDATA, 3))
    else $error("first character low byte misplaced");

  a_str_rdbk: assert property (s_wr(8'h53) ##1 s_rd(8'h53)
      |=> CFG_RDATA == $past(CFG_WDATA, 2))
    else $error("last string byte readback mismatch");

  a_hub_cur: assert property (s_req(hpc_pkg::KIND_HUB, 8'h06)
      |=> DESC_BYTE == ($past(self_pwr_r) ? $past(self_cur_r)
                                          : $past(bus_cur_r)))
    else $error("hub controller current not per power mode");

  sequence s_str_tail;
    DESC_REQ && DESC_KIND == hpc_pkg::KIND_MAKER && DESC_IDX > 8'h01 &&
      (int'(DESC_IDX) >= hpc_pkg::STR_DEPTH + 2 ||
       {1'b0, DESC_IDX} >= {1'b0, maker_len_r} + 9'h002);
  endsequence

  a_str_bound: assert property (s_str_tail |=> DESC_BYTE == 8'h00)
    else $error("maker string byte sent beyond its bounds");

  a_desc_answer: assert property (DESC_REQ |=> DESC_VALID)
    else $error("descriptor byte not answered");

  a_self_cur_wr: assert property (s_wr(hpc_pkg::OFF_SELF_CUR)
      |=> self_cur_r == $past(CFG_WDATA))
    else $error("self-powered current not stored");

  a_lang_up_out: assert property (s_wr(hpc_pkg::OFF_LANG_UP) ##1
      !(CFG_WR && CFG_ADDR == hpc_pkg::OFF_LANG_UP)
      |=> LANG_ID[15:8] == $past(CFG_WDATA, 2))
    else $error("language id upper byte not updated");

  a_lang_lo_out: assert property (s_wr(hpc_pkg::OFF_LANG_LO) ##1
      !(CFG_WR && CFG_ADDR == hpc_pkg::OFF_LANG_LO)
      |=> LANG_ID[7:0] == $past(CFG_WDATA, 2))
    else $error("language id lower byte not updated");

endmodule

// [hdl/hpc_desc_gen.sv]
// Picks one descriptor byte from the live configuration registers.
// Assumes the caller registers the result; purely combinational.
`timescale 1ns/1ns
module hpc_desc_gen #(
  parameter logic [7:0]  NUM_PORTS = 8'h03,
  parameter logic [15:0] HUB_CHAR  = 16'h0000
) (
  input  wire logic [1:0] kind,
  input  wire logic [7:0] idx,
  input  wire logic       self_pwr,
  input  wire logic [7:0] bus_pwr,
  input  wire logic [7:0] self_cur,
  input  wire logic [7:0] bus_cur,
  input  wire logic [7:0] pwr_on,
  input  wire logic [7:0] lang_up,
  input  wire logic [7:0] lang_lo,
  input  wire logic [7:0] maker_len,
  input  wire logic [7:0] str_byte,
  output logic      [5:0] str_addr,
  output logic      [7:0] byte_o
);

  logic [8:0] maker_total;

  assign maker_total = {1'b0, maker_len} + {1'b0, hpc_pkg::DSC_STR_HDR};
  assign str_addr    = 6'(idx - hpc_pkg::DSC_STR_HDR);

  always_comb begin
    byte_o = 8'h00;
    unique case (hpc_pkg::hpc_kind_e'(kind))
      hpc_pkg::KIND_LANG: begin
        if (idx == 8'h00) byte_o = hpc_pkg::DSC_LANG_LEN;
        else if (idx == 8'h01) byte_o = hpc_pkg::DSC_STR_TYPE;
        else if (idx == 8'h02) byte_o = lang_lo;
        else if (idx == 8'h03) byte_o = lang_up;
      end
      hpc_pkg::KIND_MAKER: begin
        // Text beyond the programmed length is not sent; an index past
        // the storage reads zero, as the 6-bit address would wrap
        if (idx == 8'h00) byte_o = maker_total[7:0];
        else if (idx == 8'h01) byte_o = hpc_pkg::DSC_STR_TYPE;
        else if ({1'b0, idx} < maker_total &&
                 int'(idx) < hpc_pkg::STR_DEPTH + 2) byte_o = str_byte;
      end
      hpc_pkg::KIND_HUB: begin
        if (idx == 8'h00) byte_o = hpc_pkg::DSC_HUB_LEN;
        else if (idx == 8'h01) byte_o = hpc_pkg::DSC_HUB_TYPE;
        else if (idx == 8'h02) byte_o = NUM_PORTS;
        else if (idx == 8'h03) byte_o = HUB_CHAR[7:0];
        else if (idx == 8'h04) byte_o = HUB_CHAR[15:8];
        else if (idx == hpc_pkg::HUB_IDX_PWRON) byte_o = pwr_on;
        else if (idx == hpc_pkg::HUB_IDX_CUR)
          byte_o = self_pwr ? self_cur : bus_cur;
        else if (idx == 8'h08) byte_o = hpc_pkg::DSC_PWR_MASK;
      end
      hpc_pkg::KIND_POWER: begin
        if (idx == 8'h00) byte_o = bus_pwr;
      end
    endcase
  end

endmodule

// [hdl/hpc_pkg.sv]
// Constants and types of the hub power and string configuration bank.
// Assumes one byte-wide configuration port and a descriptor builder.
package hpc_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFF_BUS_PWR   = 8'h0D;
  localparam logic [7:0] OFF_SELF_CUR  = 8'h0E;
  localparam logic [7:0] OFF_BUS_CUR   = 8'h0F;
  localparam logic [7:0] OFF_PWR_ON    = 8'h10;
  localparam logic [7:0] OFF_LANG_UP   = 8'h11;
  localparam logic [7:0] OFF_LANG_LO   = 8'h12;
  localparam logic [7:0] OFF_MAKER_LEN = 8'h13;
  localparam logic [7:0] OFF_PROD_LEN  = 8'h14;
  localparam logic [7:0] OFF_SER_LEN   = 8'h15;
  localparam logic [7:0] OFF_STR_FIRST = 8'h16;
  localparam logic [7:0] OFF_STR_LAST  = 8'h53;
  localparam int         STR_DEPTH     = 62;
  localparam int         STR_AW        = 6;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_BUS_PWR   = 8'hFA;
  localparam logic [7:0] RST_SELF_CUR  = 8'h02;
  localparam logic [7:0] RST_BUS_CUR   = 8'h64;
  localparam logic [7:0] RST_PWR_ON    = 8'h00;
  localparam logic [7:0] RST_LANG_UP   = 8'h04;
  localparam logic [7:0] RST_LANG_LO   = 8'h09;
  localparam logic [7:0] RST_MAKER_LEN = 8'h00;
  localparam logic [7:0] RST_PROD_LEN  = 8'h00;
  localparam logic [7:0] RST_SER_LEN   = 8'h00;
  localparam logic [7:0] RST_STR_BYTE  = 8'h00;

  // ****************************************************************
  // Descriptor fields
  // ****************************************************************
  localparam logic [7:0] DSC_STR_TYPE  = 8'h03;
  localparam logic [7:0] DSC_LANG_LEN  = 8'h04;
  localparam logic [7:0] DSC_STR_HDR   = 8'h02;
  localparam logic [7:0] DSC_HUB_LEN   = 8'h09;
  localparam logic [7:0] DSC_HUB_TYPE  = 8'h29;
  localparam logic [7:0] DSC_PWR_MASK  = 8'hFF;
  localparam logic [7:0] HUB_IDX_PWRON = 8'h05;
  localparam logic [7:0] HUB_IDX_CUR   = 8'h06;

  typedef enum logic [1:0] {
    KIND_LANG  = 2'h0,
    KIND_MAKER = 2'h1,
    KIND_HUB   = 2'h3,
    KIND_POWER = 2'h2
  } hpc_kind_e;

  // Address falls in the maker string storage
  function automatic logic in_maker_str(input logic [7:0] addr);
    in_maker_str = (addr >= OFF_STR_FIRST) && (addr <= OFF_STR_LAST);
  endfunction

endpackage

// [hdl/hpc_str_mem.sv]
// Byte store for the maker string, one write and two read ports.
// Assumes addresses are already range checked by the caller.
`timescale 1ns/1ns
module hpc_str_mem #(
  parameter int DEPTH = 62,
  parameter int AW    = 6
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic [AW-1:0] rd_a_addr,
  output logic      [7:0]    rd_a_data,
  input  wire logic [AW-1:0] rd_b_addr,
  output logic      [7:0]    rd_b_data
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  // Flops, not RAM: every byte must clear on reset
  logic [7:0] mem_r [DEPTH];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= hpc_pkg::RST_STR_BYTE;
      end
    end else if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  // Out-of-range reads give zero
  assign rd_a_data = (int'(rd_a_addr) < DEPTH) ? mem_r[rd_a_addr] : 8'h00;
  assign rd_b_data = (int'(rd_b_addr) < DEPTH) ? mem_r[rd_b_addr] : 8'h00;

endmodule

// [sim/hpc_host_model.sv]
// Far-side model: system processor on the configuration port and
// USB host fetching descriptor bytes.
// Assumes the bank answers one edge after each strobe.
`timescale 1ns/1ns
module hpc_host_model (
  input  wire logic       clk,
  output logic      [7:0] cfg_addr,
  output logic            cfg_wr,
  output logic            cfg_rd,
  output logic      [7:0] cfg_wdata,
  input  wire logic [7:0] cfg_rdata,
  input  wire logic       cfg_rvalid,
  output logic            desc_req,
  output logic      [1:0] desc_kind,
  output logic      [7:0] desc_idx,
  input  wire logic [7:0] desc_byte,
  input  wire logic       desc_valid
);
  initial begin
    cfg_addr  = 8'h00;
    cfg_wr    = 1'b0;
    cfg_rd    = 1'b0;
    cfg_wdata = 8'h00;
    desc_req  = 1'b0;
    desc_kind = 2'h0;
    desc_idx  = 8'h00;
  end

  // ****************************************************************
  // Port cycles
  // ****************************************************************
  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_wr    <= 1'b1;
    cfg_addr  <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr    <= 1'b0;
    // Released lines must not keep the last value
    cfg_addr  <= ~a;
    cfg_wdata <= ~d;
  endtask

  task automatic cfg_read(input logic [7:0] a, output logic [7:0] d);
    logic got;
    got = 1'b0;
    d   = 8'hXX;
    @(posedge clk);
    cfg_rd   <= 1'b1;
    cfg_addr <= a;
    @(posedge clk);
    cfg_rd   <= 1'b0;
    cfg_addr <= ~a;
    for (int n = 0; n < 3 && !got; n++) begin
      @(posedge clk);
      if (cfg_rvalid === 1'b1) begin
        d   = cfg_rdata;
        got = 1'b1;
      end
    end
  endtask

  task automatic desc_read(input logic [1:0] k, input logic [7:0] i,
                           output logic [7:0] b);
    logic got;
    got = 1'b0;
    b   = 8'hXX;
    @(posedge clk);
    desc_req  <= 1'b1;
    desc_kind <= k;
    desc_idx  <= i;
    @(posedge clk);
    desc_req  <= 1'b0;
    desc_kind <= ~k;
    desc_idx  <= ~i;
    for (int n = 0; n < 3 && !got; n++) begin
      @(posedge clk);
      if (desc_valid === 1'b1) begin
        b   = desc_byte;
        got = 1'b1;
      end
    end
  endtask

  // Back-to-back strobes, no idle edge between write and read
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
    @(posedge clk);
    cfg_wr    <= 1'b1;
    cfg_addr  <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr    <= 1'b0;
    cfg_rd    <= 1'b1;
    cfg_wdata <= ~d;
    @(posedge clk);
    cfg_rd    <= 1'b0;
    cfg_addr  <= ~a;
    @(posedge clk);
    q = (cfg_rvalid === 1'b1) ? cfg_rdata : 8'hXX;
  endtask

  // Two writes on consecutive edges, descriptor request on the next
  task automatic wr2_desc(input logic [7:0] a1, input logic [7:0] d1,
                          input logic [7:0] a2, input logic [7:0] d2,
                          input logic [1:0] k, input logic [7:0] i,
                          output logic [7:0] b);
    @(posedge clk);
    cfg_wr    <= 1'b1;
    cfg_addr  <= a1;
    cfg_wdata <= d1;
    @(posedge clk);
    cfg_addr  <= a2;
    cfg_wdata <= d2;
    @(posedge clk);
    cfg_wr    <= 1'b0;
    cfg_addr  <= ~a2;
    cfg_wdata <= ~d2;
    desc_req  <= 1'b1;
    desc_kind <= k;
    desc_idx  <= i;
    @(posedge clk);
    desc_req  <= 1'b0;
    desc_kind <= ~k;
    desc_idx  <= ~i;
    @(posedge clk);
    b = (desc_valid === 1'b1) ? desc_byte : 8'hXX;
  endtask

  // ****************************************************************
  // Software policy
  // ****************************************************************
  // Board load is folded in because an embedded peripheral reports zero
  task automatic program_power(input int bus_ma, input int board_ma,
                               input int self_ma, input int cur_ma,
                               input int on_ms, input logic has_switch);
    int self_lim;
    self_lim = (self_ma > 100) ? 100 : self_ma;
    cfg_write(hpc_pkg::OFF_BUS_PWR, 8'((bus_ma + board_ma) / 2));
    cfg_write(hpc_pkg::OFF_SELF_CUR, 8'(self_lim));
    cfg_write(hpc_pkg::OFF_BUS_CUR, 8'(cur_ma));
    cfg_write(hpc_pkg::OFF_PWR_ON,
              has_switch ? 8'(on_ms / 2) : 8'h00);
  endtask

  task automatic put_char(input int n, input logic [15:0] ch);
    cfg_write(8'(hpc_pkg::OFF_STR_FIRST + 2 * n), ch[7:0]);
    cfg_write(8'(hpc_pkg::OFF_STR_FIRST + 2 * n + 1), ch[15:8]);
  endtask
endmodule

// [sim/hub_power_and_string_config_regs_bench.sv]
// Self-checking bench of the hub power and string configuration bank.
// Assumes the host model drives both ports; the bench owns reset.
`timescale 1ns/1ns
module hub_power_and_string_config_regs_bench;
  logic        clk;
  logic        rst_n;
  logic        self_pwr_pin;
  logic [7:0]  cfg_addr;
  logic        cfg_wr;
  logic        cfg_rd;
  logic [7:0]  cfg_wdata;
  logic [7:0]  cfg_rdata;
  logic        cfg_rvalid;
  logic        desc_req;
  logic [1:0]  desc_kind;
  logic [7:0]  desc_idx;
  logic [7:0]  desc_byte;
  logic        desc_valid;
  logic [15:0] lang_id;
  int          err_total;
  int          n_tests;

  hpc_cfg_regs i_dut (
    .CLK(clk), .RST_N(rst_n), .CFG_ADDR(cfg_addr), .CFG_WR(cfg_wr),
    .CFG_RD(cfg_rd), .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata),
    .CFG_RVALID(cfg_rvalid), .SELF_PWR_PIN(self_pwr_pin),
    .DESC_REQ(desc_req), .DESC_KIND(desc_kind), .DESC_IDX(desc_idx),
    .DESC_BYTE(desc_byte), .DESC_VALID(desc_valid), .LANG_ID(lang_id)
  );

  hpc_host_model i_host (
    .clk(clk), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .desc_req(desc_req), .desc_kind(desc_kind), .desc_idx(desc_idx),
    .desc_byte(desc_byte), .desc_valid(desc_valid)
  );

  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    i_host.cfg_read(a, v);
    check({8'h00, v}, {8'h00, exp});
  endtask

  task automatic ds_chk(input logic [1:0] k, input logic [7:0] i,
                        input logic [7:0] exp);
    logic [7:0] v;
    i_host.desc_read(k, i, v);
    check({8'h00, v}, {8'h00, exp});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_values();
    rd_chk(8'h0D, 8'hFA);
    rd_chk(8'h0E, 8'h02);
    rd_chk(8'h0F, 8'h64);
    rd_chk(8'h10, 8'h00);
    rd_chk(8'h11, 8'h04);
    rd_chk(8'h12, 8'h09);
    rd_chk(8'h13, 8'h00);
    rd_chk(8'h14, 8'h00);
    rd_chk(8'h15, 8'h00);
    rd_chk(8'h16, 8'h00);
    rd_chk(8'h53, 8'h00);
    check(lang_id, 16'h0409);
    $display("t_reset_values done");
  endtask

  task automatic t_write_readback();
    for (int i = 0; i < 9; i++) begin
      i_host.cfg_write(8'(8'h0D + i), 8'(8'hC3 ^ i));
    end
    for (int i = 0; i < 9; i++) begin
      rd_chk(8'(8'h0D + i), 8'(8'hC3 ^ i));
    end
    check(lang_id, 16'hC7C6);
    // Neighbours outside the bank must stay inert
    i_host.cfg_write(8'h54, 8'hFF);
    i_host.cfg_write(8'h0C, 8'hFF);
    rd_chk(8'h54, 8'h00);
    rd_chk(8'h0C, 8'h00);
    rd_chk(8'h00, 8'h00);
    $display("t_write_readback done");
  endtask

  task automatic t_string();
    i_host.put_char(0, 16'h2148);
    i_host.put_char(1, 16'h0469);
    i_host.cfg_write(8'h13, 8'h04);
    rd_chk(8'h16, 8'h48);
    rd_chk(8'h17, 8'h21);
    rd_chk(8'h19, 8'h04);
    ds_chk(hpc_pkg::KIND_MAKER, 8'h00, 8'h06);
    ds_chk(hpc_pkg::KIND_MAKER, 8'h01, 8'h03);
    ds_chk(hpc_pkg::KIND_MAKER, 8'h02, 8'h48);
    ds_chk(hpc_pkg::KIND_MAKER, 8'h03, 8'h21);
    ds_chk(hpc_pkg::KIND_MAKER, 8'h05, 8'h04);
    ds_chk(hpc_pkg::KIND_MAKER, 8'h06, 8'h00);
    // Shorter length must cut the descriptor at once
    i_host.cfg_write(8'h13, 8'h02);
    ds_chk(hpc_pkg::KIND_MAKER, 8'h00, 8'h04);
    ds_chk(hpc_pkg::KIND_MAKER, 8'h04, 8'h00);
    i_host.cfg_write(8'h53, 8'h7E);
    rd_chk(8'h53, 8'h7E);
    $display("t_string done");
  endtask

  task automatic t_hub();
    logic [7:0] exp [9] = '{8'h09, 8'h29, 8'h03, 8'h00, 8'h00,
                            8'h0A, 8'h5A, 8'h00, 8'hFF};
    self_pwr_pin <= 1'b0;
    i_host.program_power(300, 100, 150, 90, 20, 1'b1);
    rd_chk(8'h0E, 8'h64);
    for (int i = 0; i < 9; i++) begin
      ds_chk(hpc_pkg::KIND_HUB, 8'(i), exp[i]);
    end
    ds_chk(hpc_pkg::KIND_HUB, 8'h09, 8'h00);
    ds_chk(hpc_pkg::KIND_POWER, 8'h00, 8'hC8);
    // Pin passes a three-flop synchroniser first
    self_pwr_pin <= 1'b1;
    repeat (6) @(posedge clk);
    ds_chk(hpc_pkg::KIND_HUB, 8'h06, 8'h64);
    i_host.program_power(300, 100, 8, 90, 20, 1'b0);
    ds_chk(hpc_pkg::KIND_HUB, 8'h05, 8'h00);
    ds_chk(hpc_pkg::KIND_HUB, 8'h06, 8'h08);
    i_host.cfg_write(8'h11, 8'h08);
    i_host.cfg_write(8'h12, 8'h07);
    ds_chk(hpc_pkg::KIND_LANG, 8'h00, 8'h04);
    ds_chk(hpc_pkg::KIND_LANG, 8'h01, 8'h03);
    ds_chk(hpc_pkg::KIND_LANG, 8'h02, 8'h07);
    ds_chk(hpc_pkg::KIND_LANG, 8'h03, 8'h08);
    check(lang_id, 16'h0807);
    $display("t_hub done");
  endtask

  task automatic t_back_to_back();
    logic [7:0] v;
    i_host.wr_rd(8'h0D, 8'h5C, v);
    check({8'h00, v}, 16'h005C);
    i_host.wr_rd(8'h53, 8'hA5, v);
    check({8'h00, v}, 16'h00A5);
    i_host.wr2_desc(8'h10, 8'h11, 8'h10, 8'h32, hpc_pkg::KIND_HUB, 8'h05,
                    v);
    check({8'h00, v}, 16'h0032);
    i_host.wr2_desc(8'h16, 8'h6B, 8'h13, 8'h02, hpc_pkg::KIND_MAKER,
                    8'h02, v);
    check({8'h00, v}, 16'h006B);
    // Index past the storage must read zero, not wrap to the first byte
    i_host.wr2_desc(8'h13, 8'h50, 8'h13, 8'h50, hpc_pkg::KIND_MAKER,
                    8'h42, v);
    check({8'h00, v}, 16'h0000);
    $display("t_back_to_back done");
  endtask

  // ****************************************************************
  // Run control
  // ****************************************************************
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Whole run needs a few hundred cycles; this is ample margin
  initial begin
    #100000;
    err_total++;
    stop_test();
  end

  initial begin
    err_total    = 0;
    n_tests      = 0;
    rst_n        = 1'b0;
    self_pwr_pin = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_write_readback();
    t_string();
    t_hub();
    t_back_to_back();
    // Second reset in mid-run must restore every default
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_values();
    stop_test();
  end
endmodule
